// ===== logic/io_port_pkg.sv
// constants and types shared by the i/o port mode control design
package io_port_pkg;
    // register offsets (word aligned byte addresses)
    localparam logic [7:0] OFS_DATA_IN = 8'h00;
    localparam logic [7:0] OFS_DATA_OUT = 8'h04;
    localparam logic [7:0] OFS_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0C;
    localparam logic [7:0] OFS_MODE_STATUS = 8'h10;
    // port selector field of the address
    localparam int PORT_SEL_LSB = 8;
    localparam int NUM_PORTS = 7;
    // port indices
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_F = 3'h5;
    localparam logic [2:0] PORT_G = 3'h6;
    // reset value and port d direction mask
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [7:0] PORT_D_MASK = 8'h0F;
    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;
    // source chosen for one pin by the output multiplexer
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_DATA_OUT,
        SRC_ADDRESS,
        SRC_LOGIC_ARRAY
    } pin_source_type;
endpackage

// ===== logic/io_pin_sync_if.sv
// interface carrying raw pin levels into the synchroniser and filtered levels out
`timescale 1ns/100ps
`default_nettype none
interface io_pin_sync_if;
    logic [55:0] raw;
    logic [55:0] level;
    modport owner (output raw, input level);
    modport sync (input raw, output level);
endinterface
`default_nettype wire

// ===== logic/io_pin_sync.sv
// three-stage pin synchroniser, a rise counts once stages two and three are both high, a fall as soon as they differ
`timescale 1ns/100ps
`default_nettype none
module io_pin_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // pins
    io_pin_sync_if.sync pins
);
    logic [55:0] stage1;
    logic [55:0] stage2;
    logic [55:0] stage3;
    logic [55:0] level;

    // shift register, first stage read only by the second
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= pins.raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // set the level where two and three are both high, clear it where they differ
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            level <= '0;
        else
            level <= (level & ~(stage2 ^ stage3)) | (stage2 & stage3);
    end

    assign pins.level = level;
endmodule
`default_nettype wire

// ===== logic/io_port_mode_control.sv
// operating-mode logic for seven i/o ports with a wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module io_port_mode_control #(
    // configuration, fixed when the device is programmed
    parameter logic [55:0] CFG_ARRAY_OUT = '0,
    parameter logic [55:0] CFG_ARRAY_IN = '0,
    parameter logic [55:0] CFG_ADDR_IN = '0,
    parameter logic [55:0] CFG_DECODE_IN = '0,
    parameter logic CFG_DATA_PORT = 1'b0,
    parameter logic CFG_BOOT_PATTERN_EN = 1'b0,
    parameter logic CFG_BOOT_HOST = 1'b0,
    parameter logic CFG_BURST_HOST = 1'b0,
    parameter logic CFG_ADDR_IN_LATCH = 1'b0,
    parameter logic [7:0] CFG_JTAG_PINS_E = 8'h00,
    parameter logic [15:0] CFG_BOOT_PATTERN = 16'h0000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // host bus state for the boot pattern and address latch
    input wire logic host_reset_b,
    input wire logic host_bus_active,
    input wire logic address_strobe,
    input wire logic [15:0] host_address,
    // logic arrays
    input wire logic [55:0] general_logic_array_out,
    input wire logic [55:0] general_logic_array_oe,
    output logic [55:0] array_pin_in,
    output logic [55:0] memory_decode_array_in,
    // port pins, seven ports of eight bits, A at the bottom
    input wire logic [55:0] pin_in,
    output logic [55:0] pin_out,
    output logic [55:0] pin_oe
);
    // pin bit span of one port
    function automatic logic [7:0] port_bits(input logic [55:0] v, input logic [2:0] p);
        port_bits = v[p*8 +: 8];
    endfunction

    // port with a control register (E,F,G)
    function automatic logic has_control(input logic [2:0] p);
        has_control = (p == io_port_pkg::PORT_E) || (p == io_port_pkg::PORT_F) ||
                      (p == io_port_pkg::PORT_G);
    endfunction

    logic [7:0] data_out [io_port_pkg::NUM_PORTS];
    logic [7:0] direction [io_port_pkg::NUM_PORTS];
    logic [7:0] control [io_port_pkg::NUM_PORTS];
    logic [55:0] pin_level;
    logic [15:0] latched_address;
    logic [15:0] address_in_latch;
    logic reset_seen;
    logic [2:0] host_reset_sync;
    logic host_reset_level;
    logic wb_req;
    logic [2:0] reg_port;
    logic [7:0] reg_ofs;
    logic port_ok;
    logic [7:0] next_read;
    logic [55:0] next_out;
    logic [55:0] next_oe;

    io_pin_sync_if sync_bus ();

    // pins pass the three-stage synchroniser; every pin keeps its own input
    assign sync_bus.raw = pin_in;
    assign pin_level = sync_bus.level;

    io_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pins(sync_bus)
    );

    // request decode, each register one aligned word per port
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign reg_port = wb_adr_i[io_port_pkg::PORT_SEL_LSB +: 3];
    assign reg_ofs = wb_adr_i[7:0];
    assign port_ok = reg_port < 3'(io_port_pkg::NUM_PORTS);

    // one wait state: ack one cycle after the request, dropped next cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    // host-writable registers, cleared at reset; config modes are parameters only
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            for (int p = 0; p < io_port_pkg::NUM_PORTS; p++)
            begin
                data_out[p] <= io_port_pkg::RESET_REG;
                direction[p] <= io_port_pkg::RESET_REG;
                control[p] <= io_port_pkg::RESET_REG;
            end
        end
        else if (wb_req && wb_we_i && wb_sel_i[0] && port_ok)
        begin
            case (reg_ofs)
                io_port_pkg::OFS_DATA_OUT:
                    data_out[reg_port] <= wb_dat_i[7:0];
                io_port_pkg::OFS_DIRECTION:
                    direction[reg_port] <= (reg_port == io_port_pkg::PORT_D) ?
                        (wb_dat_i[7:0] & io_port_pkg::PORT_D_MASK) : wb_dat_i[7:0];
                io_port_pkg::OFS_CONTROL:
                    if (has_control(reg_port))
                        control[reg_port] <= wb_dat_i[7:0];
                default:
                    ;
            endcase
        end
    end

    // read multiplexer; data-in shows the live pin level
    always_comb
    begin
        next_read = 8'h00;
        if (port_ok)
        begin
            case (reg_ofs)
                io_port_pkg::OFS_DATA_IN:
                    next_read = port_bits(pin_level, reg_port);
                io_port_pkg::OFS_DATA_OUT:
                    next_read = data_out[reg_port];
                io_port_pkg::OFS_DIRECTION:
                    next_read = direction[reg_port];
                io_port_pkg::OFS_CONTROL:
                    next_read = has_control(reg_port) ? control[reg_port] : 8'h00;
                io_port_pkg::OFS_MODE_STATUS:
                    next_read = {5'h00, reset_seen, CFG_DATA_PORT, CFG_BOOT_PATTERN_EN};
                default:
                    next_read = 8'h00;
            endcase
        end
    end

    // read data registered with the ack, upper bits zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_req && !wb_we_i)
            wb_dat_o <= {24'h00_0000, next_read};
        else
            wb_dat_o <= 32'h0000_0000;
    end

    // multiplexed host address latched on the strobe for address out
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            latched_address <= 16'h0000;
        else if (address_strobe)
            latched_address <= host_address;
    end

    // high address inputs on A,F optionally captured by the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            address_in_latch <= 16'h0000;
        else if (address_strobe)
            address_in_latch <= {pin_level[47:40], pin_level[7:0]};
    end

    // host reset line: three flops, stage one read only by stage two
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            host_reset_sync <= 3'h0;
        else
            host_reset_sync <= {host_reset_sync[1:0], host_reset_b};
    end

    // host reset level follows once stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            host_reset_level <= 1'b0;
        else if (host_reset_sync[1] == host_reset_sync[2])
            host_reset_level <= host_reset_sync[2];
    end

    // tracks host reset: high while host reset is held, low after release
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            reset_seen <= 1'b0;
        else
            reset_seen <= !host_reset_level;
    end

    // pins to logic arrays; address inputs to the decode array pass the strobe latch if chosen
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            array_pin_in <= '0;
            memory_decode_array_in <= '0;
        end
        else
        begin
            array_pin_in <= pin_level & (CFG_ARRAY_IN | CFG_ADDR_IN);
            if (CFG_ADDR_IN_LATCH)
                memory_decode_array_in <= (CFG_DECODE_IN | CFG_ADDR_IN) &
                    {8'h00, address_in_latch[15:8], 32'h0, address_in_latch[7:0]};
            else
                memory_decode_array_in <= (CFG_DECODE_IN | CFG_ADDR_IN) & pin_level;
        end
    end

    // per-pin output source selection
    always_comb
    begin
        next_out = '0;
        next_oe = '0;
        for (int p = 0; p < io_port_pkg::NUM_PORTS; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                int i;
                logic [3:0] nib;
                io_port_pkg::pin_source_type src;
                i = p * 8 + b;
                nib = 4'h0;
                src = io_port_pkg::SRC_NONE;
                if (p == int'(io_port_pkg::PORT_E) && CFG_JTAG_PINS_E[b])
                    src = io_port_pkg::SRC_NONE;
                else if (CFG_DATA_PORT && p >= int'(io_port_pkg::PORT_F))
                    src = io_port_pkg::SRC_NONE;
                else if (CFG_ARRAY_OUT[i] && p <= int'(io_port_pkg::PORT_C))
                    src = general_logic_array_oe[i] ? io_port_pkg::SRC_LOGIC_ARRAY
                                                    : io_port_pkg::SRC_NONE;
                else if (has_control(3'(p)) && ((control[p][b] && direction[p][b]) ||
                         general_logic_array_oe[i]))
                    src = io_port_pkg::SRC_ADDRESS;
                else if (direction[p][b] && !(has_control(3'(p)) && control[p][b]))
                    src = io_port_pkg::SRC_DATA_OUT;
                // nibble map of the latched address
                if (p == int'(io_port_pkg::PORT_G))
                    nib = (b < 4) ? latched_address[11:8] : latched_address[15:12];
                else
                    nib = (b < 4) ? latched_address[3:0] : latched_address[7:4];
                if (src == io_port_pkg::SRC_ADDRESS && CFG_BURST_HOST && b < 4 &&
                    p != int'(io_port_pkg::PORT_G))
                    src = io_port_pkg::SRC_NONE;
                case (src)
                    io_port_pkg::SRC_DATA_OUT:
                    begin
                        next_out[i] = data_out[p][b];
                        next_oe[i] = 1'b1;
                    end
                    io_port_pkg::SRC_ADDRESS:
                    begin
                        next_out[i] = nib[b % 4];
                        next_oe[i] = 1'b1;
                    end
                    io_port_pkg::SRC_LOGIC_ARRAY:
                    begin
                        next_out[i] = general_logic_array_out[i];
                        next_oe[i] = 1'b1;
                    end
                    default:
                    begin
                        next_out[i] = 1'b0;
                        next_oe[i] = 1'b0;
                    end
                endcase
            end
        end
        // boot pattern overrides F,G while host reset held and bus idle
        if (CFG_BOOT_PATTERN_EN && CFG_BOOT_HOST && reset_seen && !host_bus_active)
        begin
            next_out[55:40] = CFG_BOOT_PATTERN;
            next_oe[55:40] = 16'hFFFF;
        end
    end

    // pins driven from flip-flops
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            pin_out <= '0;
            pin_oe <= '0;
        end
        else
        begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end

    // assertions
    a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_ack_after_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    a_boot_drive_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (CFG_BOOT_PATTERN_EN && CFG_BOOT_HOST && reset_seen && !host_bus_active) |=>
        (pin_oe[55:40] == 16'hFFFF && pin_out[55:40] == CFG_BOOT_PATTERN))
        else $error("boot pattern not driven");
    a_boot_stops_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ((!reset_seen || host_bus_active) && general_logic_array_oe[55:40] == 16'h0000 &&
        direction[5] == 8'h00 && direction[6] == 8'h00) |=> pin_oe[55:40] == 16'h0000)
        else $error("f,g driven outside boot pattern");
    a_control_abc_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        control[0] == 8'h00 && control[1] == 8'h00 && control[2] == 8'h00)
        else $error("control on A-C");
    a_jtag_pins_free: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pin_oe[39:32] & CFG_JTAG_PINS_E) == 8'h00) else $error("jtag pin driven");
    a_dir_port_d: assert property (@(posedge clk_sys) disable iff (!rst_b)
        direction[3][7:4] == 4'h0) else $error("port d upper direction");
    a_output_from_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (direction[0][0] && !CFG_ARRAY_OUT[0]) |=> (pin_oe[0] && pin_out[0] == $past(data_out[0][0])))
        else $error("port a pin 0 not from data out");
    a_addr_out_e: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (control[4][7] && direction[4][7] && !CFG_JTAG_PINS_E[7]) |=>
        (pin_oe[39] && pin_out[39] == $past(latched_address[7])))
        else $error("address out port e wrong");
    a_reset_clear: assert property (@(posedge clk_sys)
        !rst_b |=> (direction[5] == 8'h00 && control[5] == 8'h00 && pin_oe == '0))
        else $error("reset did not clear");
endmodule
`default_nettype wire

// ===== test/host_mcu_model.sv
// behavioural host controller: reset line, bus activity, address strobe, reset sampling
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model (
    // clock
    input wire logic clk_sys,
    // data lines as seen on the wires of ports f (low) and g (high)
    input wire logic [15:0] data_lines,
    // host bus outputs
    output var logic host_reset_b,
    output var logic host_bus_active,
    output var logic address_strobe,
    output var logic [15:0] host_address,
    // levels captured when the host leaves reset
    output var logic [15:0] boot_sample
);
    // host starts in reset with its bus quiet
    initial
    begin
        host_reset_b = 1'b0;
        host_bus_active = 1'b0;
        address_strobe = 1'b0;
        host_address = 16'h0000;
        boot_sample = 16'h0000;
    end
    // data lines are read at the rising edge of the reset line
    always @(posedge host_reset_b)
    begin
        boot_sample <= data_lines;
    end
    // leave reset; software sets up the address-out bits only afterwards
    task automatic leave_reset();
        @(posedge clk_sys);
        host_reset_b <= 1'b1;
    endtask
    // hold a bus cycle open for n clocks
    task automatic bus_cycle(input int n);
        @(posedge clk_sys);
        host_bus_active <= 1'b1;
        repeat (n) @(posedge clk_sys);
        host_bus_active <= 1'b0;
    endtask
    // one strobe cycle, then the muxed lines carry something else
    task automatic strobe_address(input logic [15:0] a);
        @(posedge clk_sys);
        address_strobe <= 1'b1;
        host_address <= a;
        @(posedge clk_sys);
        address_strobe <= 1'b0;
        host_address <= ~a;
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the i/o port mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [15:0] BOOT_PAT = 16'h3CA5;
    logic clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    wire logic host_reset_b, host_bus_active, address_strobe;
    wire logic [15:0] host_address, boot_sample;
    logic [55:0] glo, gloe, array_pin_in, decode_in, pin_out, pin_oe, ext_pins;
    wire logic [55:0] pin_in;
    int error_cnt, n_checks;
    logic [7:0] rd;
    // wire level: the block wins where it drives, else the outside world
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
    io_port_mode_control #(.CFG_ARRAY_OUT(56'h00_0000_0000_00F0),
        .CFG_ARRAY_IN(56'h00_0000_0000_FF00), .CFG_ADDR_IN(56'h00_0000_00FF_0000),
        .CFG_BOOT_PATTERN_EN(1'b1), .CFG_BOOT_HOST(1'b1), .CFG_BOOT_PATTERN(BOOT_PAT),
        .CFG_JTAG_PINS_E(8'h01))
    i_io_port_mode_control (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .host_reset_b(host_reset_b), .host_bus_active(host_bus_active),
        .address_strobe(address_strobe), .host_address(host_address),
        .general_logic_array_out(glo), .general_logic_array_oe(gloe),
        .array_pin_in(array_pin_in), .memory_decode_array_in(decode_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    host_mcu_model i_host_mcu_model (.clk_sys(clk_sys), .data_lines(pin_in[55:40]),
        .host_reset_b(host_reset_b), .host_bus_active(host_bus_active),
        .address_strobe(address_strobe), .host_address(host_address),
        .boot_sample(boot_sample));
    // clock at 100 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // compare one value
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // let n edges pass, then look at settled outputs
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        // wait for ack however long it takes; only the watchdog ends a hang
        do
            @(posedge clk_sys);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [11:0] adr, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, adr, d, q);
    endtask
    // pattern on f,g while the host is held in reset and its bus is quiet
    task automatic t_boot();
        step(6);
        check({pin_oe[55:40], pin_out[55:40]}, {16'hFFFF, BOOT_PAT});
        fork
            i_host_mcu_model.bus_cycle(8);
        join_none
        step(5);
        check(pin_oe[55:40], 16'h0000);
        step(8);
        check(pin_oe[55:40], 16'hFFFF);
        i_host_mcu_model.leave_reset();
        step(8);
        check(boot_sample, BOOT_PAT);
        check(pin_oe[55:40], 16'h0000);
    endtask
    // cleared registers, e-g outputs off and mode status at start
    task automatic t_reset_values();
        wb_xfer(1'b0, 12'h408, 8'h00, rd);
        check(rd, 8'h00);
        wb_xfer(1'b0, 12'h60C, 8'h00, rd);
        check(rd, 8'h00);
        wb_xfer(1'b0, 12'h004, 8'h00, rd);
        check(rd, 8'h00);
        check(pin_oe[55:32], 24'h000000);
        wb_xfer(1'b0, 12'h010, 8'h00, rd);
        check(rd, 8'h01);
    endtask
    // host i/o on ports a and e: output, direction change, live input read
    task automatic t_host_io();
        wr(12'h004, 8'h01);
        wr(12'h008, 8'h01);
        step(4);
        check({pin_oe[0], pin_out[0]}, 2'h3);
        wb_xfer(1'b0, 12'h000, 8'h00, rd);
        check(rd, 8'h01);
        wr(12'h40C, 8'h00);
        wr(12'h404, 8'h5A);
        wr(12'h408, 8'hFF);
        step(2);
        check({pin_oe[39:32], pin_out[39:32]}, 16'hFE5A);
        wr(12'h408, 8'h0F);
        step(2);
        check(pin_oe[39:32], 8'h0E);
        wr(12'h408, 8'h00);
        ext_pins[39:32] <= 8'hC3;
        step(6);
        wb_xfer(1'b0, 12'h400, 8'h00, rd);
        check(rd, 8'hC3);
    endtask
    // latched address out on e, f and g, set up by software at run time
    task automatic t_addr_out();
        wr(12'h50C, 8'hFF);
        wr(12'h508, 8'hFF);
        wr(12'h60C, 8'hFF);
        wr(12'h608, 8'hFF);
        wr(12'h40C, 8'hF0);
        wr(12'h408, 8'hF0);
        i_host_mcu_model.strobe_address(16'hBE27);
        step(4);
        check({pin_oe[55:40], pin_out[55:40]}, 32'hFFFF_BE27);
        check({pin_oe[39:32], pin_out[39:36]}, 12'hF02);
        wr(12'h508, 8'h00);
        step(2);
        check(pin_oe[47:40], 8'h00);
    endtask
    // refused and reduced accesses
    task automatic t_refused();
        wr(12'h00C, 8'hFF);
        wb_xfer(1'b0, 12'h00C, 8'h00, rd);
        check(rd, 8'h00);
        wr(12'h308, 8'hFF);
        wb_xfer(1'b0, 12'h308, 8'h00, rd);
        check(rd, 8'h0F);
        wb_xfer(1'b0, 12'h014, 8'h00, rd);
        check(rd, 8'h00);
        wb_xfer(1'b0, 12'h708, 8'h00, rd);
        check(rd, 8'h00);
        // a write without byte lane 0 leaves the register alone
        wb_sel_i <= 4'h0;
        wr(12'h404, 8'hFF);
        wb_sel_i <= 4'h1;
        wb_xfer(1'b0, 12'h404, 8'h00, rd);
        check(rd, 8'h5A);
    endtask
    // array outputs, array inputs and address inputs; port b direction left at 0
    task automatic t_arrays();
        gloe[7:4] <= 4'hF;
        glo[7:4] <= 4'hA;
        ext_pins[23:8] <= 16'h6996;
        step(6);
        check({pin_oe[7:0], pin_out[7:4]}, 12'hF1A);
        check(array_pin_in[15:8], 8'h96);
        check(decode_in[23:16], 8'h69);
        @(posedge clk_sys);
        gloe[7:4] <= 4'h0;
        step(3);
        check(pin_oe[7:4], 4'h0);
    endtask
    // hang guard
    initial
    begin
        #400000;
        error_cnt++;
        wrap_up();
    end
    // main sequence
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h00000000;
        glo = '0;
        gloe = '0;
        ext_pins = '0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_boot();
        t_reset_values();
        t_host_io();
        t_addr_out();
        t_refused();
        t_arrays();
        wrap_up();
    end
endmodule
`default_nettype wire
